// File: shared/bctr_pkg.sv
// bus-cycle trace recorder: constants, register map and record layouts.
// assumes a 20 MHz clock that is the monitored target's own bus clock.
package bctr_pkg;
  localparam int unsigned BCTR_CLK_HZ     = 20000000;
  localparam int unsigned BCTR_CLK_NS     = 1000000000 / BCTR_CLK_HZ;
  localparam int unsigned BCTR_DEPTH      = 32768;
  localparam int unsigned BCTR_FIFO_DEPTH = 8;
  localparam int unsigned BCTR_CLK_MAX    = 8;
  localparam int unsigned BCTR_TS_SEL_MAX = 9;
  // tick periods in ns, index 0 means time stamping off
  localparam int unsigned BCTR_TICK_NS [0:9] = '{0, 125, 250, 500, 1000, 2000, 4000, 8000, 16000, 100000};

  // apb byte offsets
  localparam logic [11:0] BCTR_OFS_CTRL    = 12'h000;
  localparam logic [11:0] BCTR_OFS_STATUS  = 12'h004;
  localparam logic [11:0] BCTR_OFS_COUNT   = 12'h008;
  localparam logic [11:0] BCTR_OFS_RDIDX   = 12'h00c;
  localparam logic [11:0] BCTR_OFS_RECADR  = 12'h010;
  localparam logic [11:0] BCTR_OFS_RECDAT  = 12'h014;
  localparam logic [11:0] BCTR_OFS_RECPAY  = 12'h018;
  localparam logic [11:0] BCTR_OFS_RECDIF  = 12'h01c;
  localparam logic [11:0] BCTR_OFS_TSNOW   = 12'h020;

  // control fields
  localparam int unsigned BCTR_CTRL_EN     = 0;
  localparam int unsigned BCTR_CTRL_BYTE   = 1;
  localparam int unsigned BCTR_CTRL_TS_LSB = 4;
  localparam int unsigned BCTR_CTRL_DL_LSB = 16;
  localparam logic [31:0] BCTR_CTRL_RST    = 32'h0000_0001;

  // status bits
  localparam int unsigned BCTR_ST_TRACING  = 0;
  localparam int unsigned BCTR_ST_DELAYED  = 1;
  localparam int unsigned BCTR_ST_WRAPPED  = 2;
  localparam int unsigned BCTR_ST_OVERRUN  = 3;
  localparam int unsigned BCTR_ST_RDBUSY   = 4;
  localparam int unsigned BCTR_ST_FEMPTY   = 5;
  localparam int unsigned BCTR_ST_RDVALID  = 6;

  typedef enum logic [2:0] {
    AREA_ROM, AREA_RAM, AREA_IO8, AREA_IO16, AREA_EXTERNAL8, AREA_EXTERNAL16, AREA_XFER_RAM
  } bctr_area_e;

  typedef enum logic [2:0] {
    BS_TRANSFER_CONTROLLER, BS_PREFETCH_STATUS, BS_CPU_DATA, BS_REFRESH, BS_DMA_CONTROLLER_CYCLE
  } bctr_bstat_e;

  typedef enum logic [1:0] {
    TR_IDLE  = 2'b00,
    TR_RUN   = 2'b01,
    TR_DELAY = 2'b11,
    TR_STOP  = 2'b10
  } bctr_state_e;

  // target pins, sampled every clock
  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic        wr;
    bctr_area_e  area;
    bctr_bstat_e bstat;
    logic        cyc_end;
    logic [3:0]  probe;
    logic        nmi;
    logic [7:0]  irq;
    logic        run;
    logic        stop_evt;
  } bctr_tgt_s;

  typedef struct packed {
    bctr_area_e  area;
    bctr_bstat_e bstat;
    logic [3:0]  clk_cnt;
    logic        clock_count_overflow;
    logic [3:0]  probe;
    logic        nmi;
    logic [7:0]  irq;
  } bctr_stat_s;

  typedef struct packed {
    logic [23:0] addr;
    logic [15:0] data;
    logic        wr;
    logic        ts_mode;
    logic [31:0] payload;
    logic [31:0] diff;
  } bctr_rec_s;
endpackage

// File: verilog/bctr_top.sv
// bus-cycle trace recorder: capture, staging fifo, trace buffer, apb slave.
// assumes clk is the target bus clock; target pins are still resynchronised.
//
// Operation
// - newest record reads as index zero, older ones as -1, -2 and onward.
// - with stop delay, stop-condition record is zero, delay records +1, +2.
// - data bus stored per cycle, byte or halfword wide.
// - each record has a read or write direction flag.
// - each record holds the accessed area code.
// - each record holds the bus status code.
// - clocks per bus cycle stored 1 to 8, overflow flag beyond 8.
// - four probe pins stored, probe 4 most significant.
// - non-maskable interrupt level stored per cycle.
// - eight interrupt request levels stored, one bit each.
// - with time stamping, time stamp replaces the status fields.
// - time stamp clears at every program start.
// - time stamp advances at the selected tick period.
// - difference to preceding record's time stamp kept with record.
// - buffer keeps up to 32768 records of the last run.
// - when full, new records overwrite the oldest ones.
// - time stamp is 32 bits, wraps to zero and keeps counting.
// - tick selectable among off and nine periods; off stores no time stamps.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/10ps

module bctr_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 8
) (
  // clock and control
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         ce,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0] mem_ff [D];
  logic [AW-1:0] rp_ff;
  logic [AW-1:0] wp_ff;
  logic [AW:0]   cnt_ff;
  logic          push;
  logic          pop;

  if (D < 2 || D != (1 << AW)) begin : g_chk
    $error("fifo depth must be a power of two, at least 2");
  end

  assign in_ready  = (cnt_ff != (AW+1)'(D));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rp_ff];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage, written only on accepted pushes
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_ff[wp_ff] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk) begin
    if (srst) begin
      rp_ff  <= '0;
      wp_ff  <= '0;
      cnt_ff <= '0;
    end else if (ce) begin
      if (push) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module bctr_top
  import bctr_pkg::*;
#(
  parameter int unsigned DEPTH = BCTR_DEPTH,
  parameter int unsigned AW    = 15,
  parameter int unsigned DLY_W = 16
) (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // apb slave
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // target pins
  input  wire bctr_tgt_s   tgt_pins,
  // status
  output logic             tracing
);
  if (DEPTH != (1 << AW) || DLY_W > 16) begin : g_chk
    $error("depth must equal 2**AW and delay width at most 16");
  end

  bctr_tgt_s    tgt_s1_ff;
  bctr_tgt_s    tgt_ff;
  logic         run_d_ff;
  logic         prefetch_status_start;
  logic         prefetch_status_halt;
  logic [31:0]  ctrl_ff;
  logic [3:0]   ts_sel;
  logic [DLY_W-1:0] dly;
  logic         ts_on;
  logic [16:0]  acc_ff;
  logic [17:0]  acc_nxt;
  logic [16:0]  period;
  logic [31:0]  ts_ff;
  logic [31:0]  last_ts_ff;
  logic [3:0]   clk_cnt_ff;
  bctr_state_e  state_ff;
  logic         capture;
  logic         accepted;
  logic [AW-1:0] cap_ptr_ff;
  logic [AW-1:0] zero_ptr_ff;
  logic [AW:0]  count_ff;
  logic [DLY_W-1:0] post_ff;
  logic         delayed_ff;
  logic         wrapped_ff;
  logic         overrun_ff;
  bctr_stat_s   stat;
  bctr_rec_s    rec;
  logic         f_in_ready;
  logic         f_out_valid;
  logic         f_out_ready;
  bctr_rec_s    f_out_data;
  bctr_rec_s    buf_ff [DEPTH];
  logic [AW-1:0] mem_wp_ff;
  logic         rd_go_ff;
  logic [AW-1:0] rd_addr_ff;
  logic [15:0]  rd_idx_ff;
  logic         rd_valid_ff;
  bctr_rec_s    rec_rd_ff;
  logic [AW-1:0] zero_pt;
  logic signed [17:0] idx_s;
  logic signed [17:0] older_max;
  logic         idx_ok;
  logic         setup;
  logic         acc_ph;
  logic         wr_ok;
  logic         mapped;
  logic [31:0]  rd_mux;
  logic [31:0]  status;
  logic [31:0]  prdata_ff;
  logic         pready_ff;
  logic         pslverr_ff;

  assign ts_sel = ctrl_ff[BCTR_CTRL_TS_LSB +: 4];
  assign dly    = ctrl_ff[BCTR_CTRL_DL_LSB +: DLY_W];
  assign ts_on  = (ts_sel != 4'h0) && (ts_sel <= 4'(BCTR_TS_SEL_MAX));

  // two-stage resync of every target pin before any logic looks at it
  always_ff @(posedge clk) begin
    if (srst) begin
      tgt_s1_ff <= '0;
      tgt_ff    <= '0;
      run_d_ff  <= 1'b0;
    end else if (ce) begin
      tgt_s1_ff <= tgt_pins;
      tgt_ff    <= tgt_s1_ff;
      run_d_ff  <= tgt_ff.run;
    end
  end

  assign prefetch_status_start = tgt_ff.run & ~run_d_ff;
  assign prefetch_status_halt  = ~tgt_ff.run & run_d_ff;

  // tick generator: ns accumulator keeps 125 ns exact on average at 50 ns clocks,
  // at the cost of a jitter of one clock between ticks
  assign period  = ts_on ? 17'(BCTR_TICK_NS[ts_sel]) : 17'h1ffff;
  assign acc_nxt = {1'b0, acc_ff} + 18'(BCTR_CLK_NS);

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_ff <= '0;
      ts_ff  <= '0;
    end else if (ce) begin
      if (prefetch_status_start) begin
        acc_ff <= '0;
        ts_ff  <= '0;
      end else if (ts_on) begin
        if (acc_nxt >= {1'b0, period}) begin
          acc_ff <= 17'(acc_nxt - {1'b0, period});
          ts_ff  <= ts_ff + 32'h1; // natural 32-bit wrap to zero
        end else begin
          acc_ff <= acc_nxt[16:0];
        end
      end
    end
  end

  // clocks of the current bus cycle, saturating one above the maximum
  always_ff @(posedge clk) begin
    if (srst) begin
      clk_cnt_ff <= 4'h1;
    end else if (ce) begin
      if (tgt_ff.cyc_end) begin
        clk_cnt_ff <= 4'h1;
      end else if (clk_cnt_ff <= 4'(BCTR_CLK_MAX)) begin
        clk_cnt_ff <= clk_cnt_ff + 4'h1;
      end
    end
  end

  assign capture  = tgt_ff.cyc_end && (state_ff == TR_RUN || state_ff == TR_DELAY);
  assign accepted = capture & f_in_ready;

  // record assembly for the cycle ending now
  always_comb begin
    stat.area  = tgt_ff.area;
    stat.bstat = tgt_ff.bstat;
    stat.clock_count_overflow = (clk_cnt_ff > 4'(BCTR_CLK_MAX));
    stat.clk_cnt = stat.clock_count_overflow ? 4'(BCTR_CLK_MAX) : clk_cnt_ff;
    stat.probe = tgt_ff.probe; // bit 3 is probe 4
    stat.nmi   = tgt_ff.nmi;
    stat.irq   = tgt_ff.irq;
    rec.addr   = tgt_ff.addr;
    rec.data   = ctrl_ff[BCTR_CTRL_BYTE] ? {8'h00, tgt_ff.data[7:0]} : tgt_ff.data;
    rec.wr     = tgt_ff.wr;
    rec.ts_mode = ts_on;
    rec.payload = ts_on ? ts_ff : {8'h00, stat};
    rec.diff   = ts_on ? (ts_ff - last_ts_ff) : 32'h0;
  end

  // acquisition sequence: run from program start, stop on halt or stop event
  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff    <= TR_IDLE;
      zero_ptr_ff <= '0;
      post_ff     <= '0;
      delayed_ff  <= 1'b0;
    end else if (ce) begin
      case (state_ff)
        TR_IDLE, TR_STOP: begin
          if (prefetch_status_start && ctrl_ff[BCTR_CTRL_EN]) begin
            state_ff   <= TR_RUN;
            post_ff    <= '0;
            delayed_ff <= 1'b0;
          end
        end
        TR_RUN: begin
          if (prefetch_status_halt) begin
            state_ff <= TR_STOP;
          end else if (accepted && tgt_ff.stop_evt) begin
            if (dly == '0) begin
              state_ff <= TR_STOP;
            end else begin
              state_ff    <= TR_DELAY;
              zero_ptr_ff <= cap_ptr_ff; // stop record becomes index zero
              delayed_ff  <= 1'b1;
            end
          end
        end
        TR_DELAY: begin
          if (accepted) begin
            post_ff <= post_ff + 1'b1; // later records count upward
            if (post_ff + 1'b1 == dly) begin
              state_ff <= TR_STOP;
            end
          end else if (prefetch_status_halt) begin
            state_ff <= TR_STOP;
          end
        end
        default: begin
          state_ff <= TR_IDLE;
        end
      endcase
    end
  end

  // capture pointer, fill count and time stamp reference
  always_ff @(posedge clk) begin
    if (srst) begin
      cap_ptr_ff <= '0;
      count_ff   <= '0;
      wrapped_ff <= 1'b0;
      last_ts_ff <= '0;
    end else if (ce) begin
      if (prefetch_status_start && ctrl_ff[BCTR_CTRL_EN]) begin
        count_ff   <= '0; // only the latest run is kept
        wrapped_ff <= 1'b0;
        last_ts_ff <= '0;
      end else if (accepted) begin
        cap_ptr_ff <= cap_ptr_ff + 1'b1; // ring wraps over the oldest
        last_ts_ff <= ts_ff;
        if (count_ff == (AW+1)'(DEPTH)) begin
          wrapped_ff <= 1'b1;
        end else begin
          count_ff <= count_ff + 1'b1;
        end
      end
    end
  end

  // sticky overrun when the staging fifo refuses a record; set wins over clear
  always_ff @(posedge clk) begin
    if (srst) begin
      overrun_ff <= 1'b0;
    end else if (ce) begin
      if (capture && !f_in_ready) begin
        overrun_ff <= 1'b1;
      end else if (wr_ok && paddr == BCTR_OFS_STATUS && pwdata[BCTR_ST_OVERRUN]) begin
        overrun_ff <= 1'b0;
      end
    end
  end

  // staging fifo decouples capture from the single-port buffer
  bctr_fifo #(
    .W ($bits(bctr_rec_s)),
    .D (BCTR_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .srst      (srst),
    .ce        (ce),
    .in_valid  (capture),
    .in_ready  (f_in_ready),
    .in_data   (rec),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // a buffer read takes the port, so the fifo drain stalls for that cycle
  assign f_out_ready = ~rd_go_ff;

  // trace buffer: one write or one read per cycle
  always_ff @(posedge clk) begin
    if (ce) begin
      if (rd_go_ff) begin
        rec_rd_ff <= buf_ff[rd_addr_ff];
      end else if (f_out_valid) begin
        buf_ff[mem_wp_ff] <= f_out_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mem_wp_ff <= '0;
    end else if (ce && f_out_valid && f_out_ready) begin
      mem_wp_ff <= mem_wp_ff + 1'b1;
    end
  end

  // signed index to buffer slot: zero is newest, or the stop record after a delay
  assign zero_pt   = delayed_ff ? zero_ptr_ff : (cap_ptr_ff - 1'b1);
  assign idx_s     = 18'(signed'(pwdata[15:0]));
  assign older_max = signed'(18'(count_ff)) - 18'sd1 - signed'(18'(post_ff));
  assign idx_ok    = (count_ff != '0) &&
                     (idx_s >= 0 ? (idx_s <= signed'(18'(post_ff))) : (-idx_s <= older_max));

  always_ff @(posedge clk) begin
    if (srst) begin
      rd_go_ff    <= 1'b0;
      rd_addr_ff  <= '0;
      rd_idx_ff   <= '0;
      rd_valid_ff <= 1'b0;
    end else if (ce) begin
      rd_go_ff <= 1'b0;
      if (wr_ok && paddr == BCTR_OFS_RDIDX) begin
        rd_go_ff    <= 1'b1;
        rd_idx_ff   <= pwdata[15:0];
        rd_addr_ff  <= zero_pt + AW'(pwdata[15:0]);
        rd_valid_ff <= idx_ok;
      end
    end
  end

  // apb decode
  assign setup  = psel & ~penable;
  assign acc_ph = psel & penable & pready_ff;
  assign mapped = (paddr[1:0] == 2'b00) && (paddr <= BCTR_OFS_TSNOW);
  assign wr_ok  = acc_ph & pwrite & mapped;

  always_comb begin
    status = '0;
    status[BCTR_ST_TRACING] = state_ff[0];
    status[BCTR_ST_DELAYED] = delayed_ff;
    status[BCTR_ST_WRAPPED] = wrapped_ff;
    status[BCTR_ST_OVERRUN] = overrun_ff;
    status[BCTR_ST_RDBUSY]  = rd_go_ff;
    status[BCTR_ST_FEMPTY]  = ~f_out_valid;
    status[BCTR_ST_RDVALID] = rd_valid_ff;
    status[31:16]           = 16'(post_ff);
    case (paddr)
      BCTR_OFS_CTRL:   rd_mux = ctrl_ff;
      BCTR_OFS_STATUS: rd_mux = status;
      BCTR_OFS_COUNT:  rd_mux = 32'(count_ff);
      BCTR_OFS_RDIDX:  rd_mux = {16'h0000, rd_idx_ff};
      BCTR_OFS_RECADR: rd_mux = {6'h00, rec_rd_ff.ts_mode, rec_rd_ff.wr, rec_rd_ff.addr};
      BCTR_OFS_RECDAT: rd_mux = {16'h0000, rec_rd_ff.data};
      BCTR_OFS_RECPAY: rd_mux = rec_rd_ff.payload;
      BCTR_OFS_RECDIF: rd_mux = rec_rd_ff.diff;
      BCTR_OFS_TSNOW:  rd_mux = ts_ff;
      default:         rd_mux = 32'h0;
    endcase
  end

  // answer registered in setup, so every transfer completes with no wait state
  always_ff @(posedge clk) begin
    if (srst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else if (ce) begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      if (setup) begin
        prdata_ff <= (mapped && !pwrite) ? rd_mux : 32'h0;
      end
    end
  end

  // control register
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_ff <= BCTR_CTRL_RST;
    end else if (ce && wr_ok && paddr == BCTR_OFS_CTRL) begin
      ctrl_ff <= pwdata;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign tracing = state_ff[0];
endmodule

// File: bench/bctr_chk.sv
// checker for the trace recorder: apb timing, error flag and stop behaviour.
// assumes it is bound into bctr_top and sees only that module's ports.
`timescale 1ns/10ps
module bctr_chk
  import bctr_pkg::*;
#(
  parameter int unsigned DEPTH = BCTR_DEPTH,
  parameter int unsigned AW    = 15,
  parameter int unsigned DLY_W = 16
) (
  // clock, reset, enable
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        ce,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // target pins and status
  input wire bctr_tgt_s   tgt_pins,
  input wire logic        tracing
);
  logic [15:0] dly_ff;
  logic        bad_addr;

  // unmapped: past last register or unaligned
  assign bad_addr = (paddr > BCTR_OFS_TSNOW) || (paddr[1:0] != 2'b00);

  // stop delay shadow for the stop checks
  always_ff @(posedge clk) begin
    if (srst) begin
      dly_ff <= 16'h0;
    end else if (psel && penable && pready && pwrite && paddr == BCTR_OFS_CTRL) begin
      dly_ff <= pwdata[31:16];
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  property p_ready_after_setup;
    psel && !penable && ce |=> pready && (pslverr == $past(bad_addr));
  endproperty
  a_ready_after_setup: assert property (p_ready_after_setup) else $error("late apb answer");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
  property p_err_with_ready;
    pslverr |-> pready;
  endproperty
  a_err_with_ready: assert property (p_err_with_ready) else $error("lone pslverr");
  property p_write_reads_zero;
    pready && pwrite |-> prdata == 32'h0;
  endproperty
  a_write_reads_zero: assert property (p_write_reads_zero) else $error("prdata on write");
  property p_idle_quiet;
    !psel |=> !pready;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("stray pready");
  property p_reset_quiet;
    $fell(srst) |-> !pready && !pslverr && !tracing && prdata == 32'h0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("reset outputs");
  property p_stop_nodelay;
    tgt_pins.cyc_end && tgt_pins.stop_evt && tracing && dly_ff == 16'h0 |-> ##[1:5] !tracing;
  endproperty
  a_stop_nodelay: assert property (p_stop_nodelay) else $error("stop missed");
  property p_stop_delay;
    tgt_pins.cyc_end && tgt_pins.stop_evt && tracing && dly_ff != 16'h0 |=> tracing [*3];
  endproperty
  a_stop_delay: assert property (p_stop_delay) else $error("early stop");
  property p_run_fall;
    $fell(tgt_pins.run) |-> ##[1:5] !tracing;
  endproperty
  a_run_fall: assert property (p_run_fall) else $error("trace after halt");

  c_error: cover property (pready && pslverr);
  c_stop: cover property ($fell(tracing));
  c_delay: cover property (tgt_pins.cyc_end && tgt_pins.stop_evt && tracing && dly_ff != 16'h0);
endmodule

bind bctr_top bctr_chk #(.DEPTH(DEPTH), .AW(AW), .DLY_W(DLY_W)) u_bctr_chk (
  .clk(clk), .srst(srst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tgt_pins(tgt_pins), .tracing(tracing)
);

// File: bench/bctr_tgt_model.sv
// target bus model: run level and bus cycles, cyc_end on the last clock.
// assumes its tasks are called just after a rising clock edge.
`timescale 1ns/10ps
module bctr_tgt_model
  import bctr_pkg::*;
(
  // clock
  input  wire logic clk,
  // target pins
  output bctr_tgt_s tgt_pins
);
  logic run_lvl = 1'b0;

  // pins start quiet, no program running
  initial tgt_pins = '0;

  // fields flip between valid clocks so stale data is never mistaken
  task automatic idle(input int n);
    bctr_tgt_s g;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      g = bctr_tgt_s'(~tgt_pins);
      g.run = run_lvl;
      g.cyc_end = 1'b0;
      tgt_pins <= g;
    end
  endtask

  // program start or halt
  task automatic set_run(input logic r);
    run_lvl = r;
    idle(1);
  endtask

  // bus cycle of n clocks, fields valid with cyc_end
  task automatic cycle(input bctr_tgt_s c, input int n);
    bctr_tgt_s g;
    g = c;
    g.run = run_lvl;
    g.cyc_end = 1'b1;
    if (n > 1) idle(n - 1);
    @(posedge clk);
    tgt_pins <= g;
  endtask
endmodule

// File: bench/bctr_top_tb_top.sv
// bench: apb master with note queue and result watcher.
// assumes the target model drives the pins and the checker is bound in.
`timescale 1ns/10ps
module bctr_top_tb_top;
  import bctr_pkg::*;
  typedef struct {string nm; logic [31:0] e; logic [31:0] m; logic er;} bctr_note_s;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tracing;
  bctr_tgt_s   tgt_pins;
  bctr_note_s  notes[$];
  bctr_note_s  nt;
  bctr_tgt_s   sent[0:19];
  int          len[0:19];
  int          n_fail = 0;
  int          n_compared = 0;
  int          cyc = 0;

  // 20 MHz
  always #25 clk = ~clk;

  // small buffer so wrap comes quickly
  bctr_top #(.DEPTH(16), .AW(4), .DLY_W(16)) u_bctr_top (
    .clk(clk), .srst(srst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tgt_pins(tgt_pins), .tracing(tracing)
  );
  bctr_tgt_model u_bctr_tgt_model (.clk(clk), .tgt_pins(tgt_pins));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [31:0] g);
    n_compared++;
    if ($isunknown(g) || g < lo || g > hi) begin
      n_fail++;
      $display("mismatch %s expected %0d..%0d seen %h", nm, lo, hi, g);
    end
  endtask

  // budget: tick sweep takes ~36000 clocks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // each completed transfer pops the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (notes.size() == 0) begin
        chk("unexpected transfer", 32'h0, 32'h1);
      end else begin
        nt = notes.pop_front();
        chk(nt.nm, nt.e & nt.m, prdata & nt.m);
        chk({nt.nm, " error"}, {31'h0, nt.er}, {31'h0, pslverr});
      end
    end
  end

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic er = 1'b0);
    logic [31:0] q;
    notes.push_back('{"write", 32'h0, 32'h0, er});
    apb(a, 1'b1, d, q);
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic er = 1'b0);
    logic [31:0] q;
    notes.push_back('{nm, e, m, er});
    apb(a, 1'b0, 32'h0, q);
  endtask

  task automatic rd_val(input logic [11:0] a, output logic [31:0] q);
    notes.push_back('{"read", 32'h0, 32'h0, 1'b0});
    apb(a, 1'b0, 32'h0, q);
  endtask

  // record registers lag a new index: poll busy
  task automatic sel_idx(input int k);
    logic [31:0] q;
    wr(BCTR_OFS_RDIDX, 32'(k) & 32'h0000_ffff);
    q = 32'hffff_ffff;
    while (q[BCTR_ST_RDBUSY] !== 1'b0) rd_val(BCTR_OFS_STATUS, q);
  endtask

  // n: cycle length in clocks, 0 skips status
  task automatic chk_rec(input int k, input bctr_tgt_s c, input int n, input logic bm);
    logic [3:0] cc;
    sel_idx(k);
    cc = (n > 8) ? 4'h8 : 4'(n);
    rd("rec addr", BCTR_OFS_RECADR, {6'h0, 1'b0, c.wr, c.addr}, 32'h03ff_ffff);
    rd("rec data", BCTR_OFS_RECDAT, {16'h0, bm ? 8'h0 : c.data[15:8], c.data[7:0]}, 32'hffff_ffff);
    if (n > 0) rd("rec stat", BCTR_OFS_RECPAY, {8'h0, c.area, c.bstat, cc, 1'(n > 8), c.probe, c.nmi, c.irq},
                  32'hffff_ffff);
  endtask

  function automatic bctr_tgt_s rnd_cyc();
    bctr_tgt_s c;
    c = bctr_tgt_s'(63'({$urandom, $urandom}));
    c.area = bctr_area_e'(3'($urandom % 7));
    c.bstat = bctr_bstat_e'(3'($urandom % 5));
    c.stop_evt = 1'b0;
    return c;
  endfunction

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    logic [31:0] q0;
    logic [31:0] q1;
    int          tk;
    int          tab[0:3] = '{1, 8, 9, 12};
    void'($urandom(32'h50f6));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    rd("ctrl", BCTR_OFS_CTRL, BCTR_CTRL_RST, 32'hffff_ffff);
    rd("count", BCTR_OFS_COUNT, 32'h0, 32'hffff_ffff);
    rd("unmapped", 12'h024, 32'h0, 32'hffff_ffff, 1'b1);
    wr(12'h006, 32'h0, 1'b1);
    $display("test registers done");
    // 20 records into 16 places, plain stop on the last one
    wr(BCTR_OFS_CTRL, 32'h1);
    u_bctr_tgt_model.set_run(1'b1);
    u_bctr_tgt_model.idle(6);
    for (int j = 0; j < 20; j++) begin
      sent[j] = rnd_cyc();
      len[j] = (j >= 16) ? tab[j - 16] : 1 + $urandom % 12;
      sent[j].stop_evt = (j == 19);
      u_bctr_tgt_model.cycle(sent[j], len[j]);
    end
    u_bctr_tgt_model.idle(8);
    chk("tracing", 32'h0, {31'h0, tracing});
    u_bctr_tgt_model.set_run(1'b0);
    rd("count", BCTR_OFS_COUNT, 32'd16, 32'hffff_ffff);
    rd("status", BCTR_OFS_STATUS, 32'h4, 32'h7);
    for (int k = 0; k < 4; k++) chk_rec(-k, sent[19 - k], len[19 - k], 1'b0);
    chk_rec(-15, sent[4], 0, 1'b0);
    $display("test capture and wrap done");
    // delayed stop by two, byte data
    wr(BCTR_OFS_CTRL, 32'h0002_0003);
    u_bctr_tgt_model.set_run(1'b1);
    u_bctr_tgt_model.idle(6);
    for (int j = 0; j < 8; j++) begin
      sent[j] = rnd_cyc();
      sent[j].stop_evt = (j == 3);
      u_bctr_tgt_model.cycle(sent[j], 2);
    end
    u_bctr_tgt_model.idle(8);
    rd("status", BCTR_OFS_STATUS, 32'h0002_0002, 32'hffff_0003);
    rd("count", BCTR_OFS_COUNT, 32'd6, 32'hffff_ffff);
    for (int k = -1; k <= 2; k++) chk_rec(k, sent[3 + k], 2, 1'b1);
    u_bctr_tgt_model.set_run(1'b0);
    $display("test delayed stop done");
    // each tick setting over 4000 clocks
    for (int s = 1; s <= 9; s++) begin
      tk = BCTR_TICK_NS[s];
      wr(BCTR_OFS_CTRL, 32'(s) << BCTR_CTRL_TS_LSB);
      u_bctr_tgt_model.set_run(1'b1);
      u_bctr_tgt_model.idle(4);
      rd_val(BCTR_OFS_TSNOW, q0);
      chk_rng("start stamp", 0, 500 / tk + 2, q0);
      repeat (4000) @(posedge clk);
      rd_val(BCTR_OFS_TSNOW, q1);
      chk_rng("tick rate", 200000 / tk - 1, 200400 / tk + 2, q1 - q0);
      u_bctr_tgt_model.set_run(1'b0);
    end
    $display("test tick sweep done");
    // stamped records of 40 clocks at 125 ns
    wr(BCTR_OFS_CTRL, 32'h11);
    u_bctr_tgt_model.set_run(1'b1);
    u_bctr_tgt_model.idle(5);
    for (int j = 0; j < 3; j++) u_bctr_tgt_model.cycle(rnd_cyc(), 40);
    u_bctr_tgt_model.idle(4);
    u_bctr_tgt_model.set_run(1'b0);
    sel_idx(0);
    rd("stamp flag", BCTR_OFS_RECADR, 32'h0200_0000, 32'h0200_0000);
    rd_val(BCTR_OFS_RECPAY, q0);
    chk_rng("stamp", 45, 55, q0);
    rd_val(BCTR_OFS_RECDIF, q1);
    chk_rng("stamp diff", 15, 17, q1);
    $display("test time stamps done");
    tally_and_finish();
  end
endmodule
